// [design/eiac_pkg.sv]
// Constants for the ECC error inject and count block.
// Assumes one core clock; register offsets are byte addresses.
//
// What this block does
// - Lane 2 deskew 28-bit injection mask
// - Lane 3 deskew 28-bit injection mask
// - Rate FIFO mask word 0: bits 31..0
// - Rate FIFO mask word 1: bits 63..32
// - Rate FIFO mask word 2: bits 71..64
// - Rate FIFO control mask, low 24 bits
// - One corrupts a bit, zero passes it
// - Count Tx FIFO corrected single-bit errors
// - Count Tx FIFO multi-bit errors
// - Multi-bit errors only counted, never corrected
// - Count Rx FIFO corrected single-bit errors
// - Counters saturate at 255 until read
// - Reading a counter returns it and subtracts the returned value

package eiac_pkg;

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W        = 11;
  localparam logic [10:0] OFF_LANE2     = 11'h388;
  localparam logic [10:0] OFF_LANE3     = 11'h38c;
  localparam logic [10:0] OFF_RDATA_LO  = 11'h390;
  localparam logic [10:0] OFF_RDATA_MID = 11'h394;
  localparam logic [10:0] OFF_RDATA_HI  = 11'h398;
  localparam logic [10:0] OFF_RCTRL     = 11'h39c;
  localparam logic [10:0] OFF_TX_SBE    = 11'h400;
  localparam logic [10:0] OFF_TX_MBE    = 11'h404;
  localparam logic [10:0] OFF_RX_SBE    = 11'h408;
  localparam logic [10:0] OFF_IRQ_STAT  = 11'h440;
  localparam logic [10:0] OFF_IRQ_MASK  = 11'h444;

  // ==========================================================
  // Field layout
  localparam int unsigned LANE_W     = 28;
  localparam int unsigned RDATA_W    = 72;
  localparam int unsigned RDATA_MID  = 32;
  localparam int unsigned RDATA_HI   = 64;
  localparam int unsigned RDATA_HI_W = 8;
  localparam int unsigned RCTRL_W    = 24;
  localparam int unsigned NUM_EV     = 3;
  localparam int unsigned EV_TX_SBE  = 0;
  localparam int unsigned EV_TX_MBE  = 1;
  localparam int unsigned EV_RX_SBE  = 2;

  // ==========================================================
  // Reset values
  localparam logic [31:0] MASK_RST   = 32'h0;
  localparam logic [31:0] RDATA_RST  = 32'h0;

endpackage : eiac_pkg

// [design/eiac_ecc_inject_count.sv]
// ECC error injection masks and clear-on-read error counters.
// Assumes a same-clock Avalon-MM master and same-clock event pulses.
`timescale 1ns/10ps
`default_nettype none

module eiac_ecc_inject_count
  import eiac_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic [ADDR_W-1:0]   avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output var  logic [31:0]         avs_readdata_out,
  output var  logic                avs_waitrequest_out,
  input  wire logic                lane2_wr_in,
  input  wire logic [LANE_W-1:0]   lane2_word_in,
  output var  logic                lane2_wr_out,
  output var  logic [LANE_W-1:0]   lane2_word_out,
  input  wire logic                lane3_wr_in,
  input  wire logic [LANE_W-1:0]   lane3_word_in,
  output var  logic                lane3_wr_out,
  output var  logic [LANE_W-1:0]   lane3_word_out,
  input  wire logic                rdata_wr_in,
  input  wire logic [RDATA_W-1:0]  rdata_word_in,
  output var  logic                rdata_wr_out,
  output var  logic [RDATA_W-1:0]  rdata_word_out,
  input  wire logic                rctrl_wr_in,
  input  wire logic [RCTRL_W-1:0]  rctrl_word_in,
  output var  logic                rctrl_wr_out,
  output var  logic [RCTRL_W-1:0]  rctrl_word_out,
  input  wire logic                tx_single_bit_error_in,
  input  wire logic                tx_multi_bit_error_in,
  input  wire logic                rx_single_bit_error_in,
  output var  logic                irq_out
);

  localparam logic [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  // ==========================================================
  // Bus handshake
  logic                req;
  logic                acc;
  logic                wait_q;
  logic [31:0]         rd_d;
  logic [31:0]         rd_q;
  logic [LANE_W-1:0]   lane2_mask_q;
  logic [LANE_W-1:0]   lane3_mask_q;
  logic [RDATA_W-1:0]  rdata_mask_q;
  logic [RCTRL_W-1:0]  rctrl_mask_q;
  logic [NUM_EV-1:0]   ev;
  logic [NUM_EV-1:0]   stat_q;
  logic [NUM_EV-1:0]   irq_mask_q;
  logic [NUM_EV-1:0]   rd_cnt;
  logic [CNT_W-1:0]    cnt_q [NUM_EV];
  logic [CNT_W-1:0]    cnt_d [NUM_EV];

  assign req = avs_read_in | avs_write_in;
  assign acc = req & ~wait_q;
  assign ev  = {rx_single_bit_error_in, tx_multi_bit_error_in,
                tx_single_bit_error_in};

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // One wait cycle, then the answer stands for one edge
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    rd_d = RDATA_RST;
    case (avs_address_in)
      OFF_LANE2:     rd_d = 32'(lane2_mask_q);
      OFF_LANE3:     rd_d = 32'(lane3_mask_q);
      OFF_RDATA_LO:  rd_d = rdata_mask_q[RDATA_MID-1:0];
      OFF_RDATA_MID: rd_d = rdata_mask_q[RDATA_HI-1:RDATA_MID];
      OFF_RDATA_HI:  rd_d = 32'(rdata_mask_q[RDATA_W-1:RDATA_HI]);
      OFF_RCTRL:     rd_d = 32'(rctrl_mask_q);
      OFF_TX_SBE:    rd_d = 32'(cnt_q[EV_TX_SBE]);
      OFF_TX_MBE:    rd_d = 32'(cnt_q[EV_TX_MBE]);
      OFF_RX_SBE:    rd_d = 32'(cnt_q[EV_RX_SBE]);
      OFF_IRQ_STAT:  rd_d = 32'(stat_q);
      OFF_IRQ_MASK:  rd_d = 32'(irq_mask_q);
      default:       rd_d = RDATA_RST;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_q <= RDATA_RST;
    end else if (avs_read_in && wait_q) begin
      rd_q <= rd_d;
    end
  end

  assign avs_readdata_out    = rd_q;
  assign avs_waitrequest_out = wait_q;

  // ==========================================================
  // Injection masks
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lane2_mask_q <= LANE_W'(MASK_RST);
      lane3_mask_q <= LANE_W'(MASK_RST);
      rdata_mask_q <= {MASK_RST[RDATA_HI_W-1:0], MASK_RST, MASK_RST};
      rctrl_mask_q <= RCTRL_W'(MASK_RST);
    end else if (acc && avs_write_in) begin
      case (avs_address_in)
        OFF_LANE2: lane2_mask_q <= LANE_W'(be_merge(32'(lane2_mask_q),
                     avs_writedata_in, avs_byteenable_in));
        OFF_LANE3: lane3_mask_q <= LANE_W'(be_merge(32'(lane3_mask_q),
                     avs_writedata_in, avs_byteenable_in));
        OFF_RDATA_LO: rdata_mask_q[RDATA_MID-1:0] <=
                     be_merge(rdata_mask_q[RDATA_MID-1:0],
                     avs_writedata_in, avs_byteenable_in);
        OFF_RDATA_MID: rdata_mask_q[RDATA_HI-1:RDATA_MID] <=
                     be_merge(rdata_mask_q[RDATA_HI-1:RDATA_MID],
                     avs_writedata_in, avs_byteenable_in);
        OFF_RDATA_HI: rdata_mask_q[RDATA_W-1:RDATA_HI] <=
                     RDATA_HI_W'(be_merge(
                     32'(rdata_mask_q[RDATA_W-1:RDATA_HI]),
                     avs_writedata_in, avs_byteenable_in));
        OFF_RCTRL: rctrl_mask_q <= RCTRL_W'(be_merge(32'(rctrl_mask_q),
                     avs_writedata_in, avs_byteenable_in));
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Codeword corruption on write
  // XOR on store
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lane2_wr_out   <= 1'b0;
      lane3_wr_out   <= 1'b0;
      rdata_wr_out   <= 1'b0;
      rctrl_wr_out   <= 1'b0;
      lane2_word_out <= '0;
      lane3_word_out <= '0;
      rdata_word_out <= '0;
      rctrl_word_out <= '0;
    end else begin
      lane2_wr_out <= lane2_wr_in;
      lane3_wr_out <= lane3_wr_in;
      rdata_wr_out <= rdata_wr_in;
      rctrl_wr_out <= rctrl_wr_in;
      if (lane2_wr_in) begin
        lane2_word_out <= lane2_word_in ^ lane2_mask_q;
      end
      if (lane3_wr_in) begin
        lane3_word_out <= lane3_word_in ^ lane3_mask_q;
      end
      if (rdata_wr_in) begin
        rdata_word_out <= rdata_word_in ^ rdata_mask_q;
      end
      if (rctrl_wr_in) begin
        rctrl_word_out <= rctrl_word_in ^ rctrl_mask_q;
      end
    end
  end

  // ==========================================================
  // Error counters
  // multi-bit only counted
  generate
    for (genvar i = 0; i < NUM_EV; i++) begin : g_cnt
      assign rd_cnt[i] = acc && avs_read_in &&
        (avs_address_in == OFF_TX_SBE + ADDR_W'(4 * i));
      always_comb begin
        cnt_d[i] = cnt_q[i];
        if (rd_cnt[i]) begin
          cnt_d[i] = cnt_q[i] - rd_q[CNT_W-1:0];
          if (ev[i]) begin
            cnt_d[i] = cnt_d[i] + CNT_ONE;
          end
        end else if (ev[i] && cnt_q[i] != CNT_MAX) begin
          cnt_d[i] = cnt_q[i] + CNT_ONE;
        end
      end
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          cnt_q[i] <= CNT_ZERO;
        end else begin
          cnt_q[i] <= cnt_d[i];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Interrupt status and mask
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stat_q <= '0;
    end else if (acc && avs_read_in && avs_address_in == OFF_IRQ_STAT) begin
      stat_q <= (stat_q & ~rd_q[NUM_EV-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_mask_q <= '0;
    end else if (acc && avs_write_in && avs_address_in == OFF_IRQ_MASK &&
                 avs_byteenable_in[0]) begin
      irq_mask_q <= avs_writedata_in[NUM_EV-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(stat_q & irq_mask_q);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_lane2_corrupt: assert property (
    lane2_wr_in |=> lane2_wr_out &&
      lane2_word_out == $past(lane2_word_in ^ lane2_mask_q))
    else $error("lane 2 codeword not masked");

  chk_lane3_corrupt: assert property (
    lane3_wr_in |=> lane3_word_out == $past(lane3_word_in ^ lane3_mask_q))
    else $error("lane 3 codeword not masked");

  chk_rate_word_low: assert property (
    acc && avs_write_in && avs_address_in == OFF_RDATA_LO &&
      avs_byteenable_in == 4'hf
      |=> rdata_mask_q[RDATA_MID-1:0] == $past(avs_writedata_in))
    else $error("rate mask word 0 not stored");

  chk_rate_word_mid: assert property (
    rdata_wr_in |=> rdata_word_out[RDATA_HI-1:RDATA_MID] ==
      $past(rdata_word_in[RDATA_HI-1:RDATA_MID] ^
            rdata_mask_q[RDATA_HI-1:RDATA_MID]))
    else $error("rate word 1 bits not masked");

  chk_rate_word_high: assert property (
    acc && avs_read_in && avs_address_in == OFF_RDATA_HI
      |-> rd_q[31:RDATA_HI_W] == '0)
    else $error("rate word 2 reserved bits not zero");

  chk_ctrl_corrupt: assert property (
    rctrl_wr_in |=> rctrl_word_out == $past(rctrl_word_in ^ rctrl_mask_q))
    else $error("control codeword not masked");

  chk_zero_mask_pass: assert property (
    lane3_wr_in && lane3_mask_q == '0
      |=> lane3_word_out == $past(lane3_word_in))
    else $error("clear mask altered codeword");

  chk_tx_single_count: assert property (
    ev[EV_TX_SBE] && !rd_cnt[EV_TX_SBE] && cnt_q[EV_TX_SBE] != CNT_MAX
      |=> cnt_q[EV_TX_SBE] == $past(cnt_q[EV_TX_SBE]) + CNT_ONE)
    else $error("tx single-bit count missed");

  chk_tx_multi_count: assert property (
    !ev[EV_TX_MBE] && !rd_cnt[EV_TX_MBE]
      |=> $stable(cnt_q[EV_TX_MBE]))
    else $error("tx multi-bit count moved alone");

  chk_multi_no_fix: assert property (
    tx_multi_bit_error_in && !tx_single_bit_error_in &&
      !rd_cnt[EV_TX_SBE] |=> $stable(cnt_q[EV_TX_SBE]))
    else $error("multi-bit error counted as corrected");

  chk_rx_single_count: assert property (
    ev[EV_RX_SBE] && !rd_cnt[EV_RX_SBE] && cnt_q[EV_RX_SBE] != CNT_MAX
      |=> cnt_q[EV_RX_SBE] == $past(cnt_q[EV_RX_SBE]) + CNT_ONE)
    else $error("rx single-bit count missed");

  chk_count_saturate: assert property (
    cnt_q[EV_TX_SBE] == CNT_MAX && !rd_cnt[EV_TX_SBE]
      |=> cnt_q[EV_TX_SBE] == CNT_MAX)
    else $error("counter left saturation without read");

  chk_read_clears: assert property (
    avs_read_in && wait_q && avs_address_in == OFF_RX_SBE
      ##1 rd_cnt[EV_RX_SBE] && !ev[EV_RX_SBE]
      |=> cnt_q[EV_RX_SBE] == $past(cnt_q[EV_RX_SBE], 1) -
          $past(rd_q[CNT_W-1:0], 1))
    else $error("counter not cleared by read");

  chk_hold_no_write: assert property (
    !rdata_wr_in |=> $stable(rdata_word_out))
    else $error("rate codeword changed without write");

  chk_lane3_strobe: assert property (
    lane3_wr_in |=> lane3_wr_out)
    else $error("lane 3 strobe not forwarded");

  chk_lane2_reserved: assert property (
    acc && avs_read_in && avs_address_in == OFF_LANE2
      |-> rd_q[31:LANE_W] == '0)
    else $error("lane 2 reserved bits not zero");

  chk_rate_word_top: assert property (
    rdata_wr_in |=> rdata_word_out[RDATA_W-1:RDATA_HI] ==
      $past(rdata_word_in[RDATA_W-1:RDATA_HI] ^
            rdata_mask_q[RDATA_W-1:RDATA_HI]))
    else $error("rate word 2 bits not masked");

  chk_ctrl_reserved: assert property (
    acc && avs_read_in && avs_address_in == OFF_RCTRL
      |-> rd_q[31:RCTRL_W] == '0)
    else $error("control mask reserved bits not zero");

  chk_tx_multi_incr: assert property (
    ev[EV_TX_MBE] && !rd_cnt[EV_TX_MBE] && cnt_q[EV_TX_MBE] != CNT_MAX
      |=> cnt_q[EV_TX_MBE] == $past(cnt_q[EV_TX_MBE]) + CNT_ONE)
    else $error("tx multi-bit count missed");

  chk_multi_saturate: assert property (
    cnt_q[EV_TX_MBE] == CNT_MAX && !rd_cnt[EV_TX_MBE]
      |=> cnt_q[EV_TX_MBE] == CNT_MAX)
    else $error("multi-bit counter left saturation");

  chk_rx_saturate: assert property (
    cnt_q[EV_RX_SBE] == CNT_MAX && !rd_cnt[EV_RX_SBE]
      |=> cnt_q[EV_RX_SBE] == CNT_MAX)
    else $error("rx counter left saturation");

  chk_count_read_value: assert property (
    avs_read_in && wait_q && avs_address_in == OFF_TX_SBE
      |=> rd_q == 32'($past(cnt_q[EV_TX_SBE])))
    else $error("counter read returned wrong value");

  cov_count_saturates: cover property (
    cnt_q[EV_TX_MBE] == CNT_MAX && ev[EV_TX_MBE]);
  cov_read_with_event: cover property (rd_cnt[EV_TX_SBE] && ev[EV_TX_SBE]);
  cov_irq_raised: cover property ($rose(irq_out));
  cov_masked_write: cover property (lane2_wr_in && lane2_mask_q != '0);

endmodule : eiac_ecc_inject_count

`default_nettype wire

// [verification/eiac_ecc_inject_count_tb.sv]
// Self-checking bench for the ECC inject and count block.
// Assumes eiac_pkg and eiac_ecc_inject_count are compiled first.
`timescale 1ns/10ps
`default_nettype none

module eiac_ecc_inject_count_tb
  import eiac_pkg::*;
;
  // ==========================================================
  // Signals and model state
  logic         clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  logic [10:0]  addr = '0;
  logic         rd = 1'b0, wr = 1'b0;
  logic [31:0]  wdata = '0, rdata;
  logic [3:0]   be = '0;
  logic         waitreq, irq;
  logic         l2w = 0, l3w = 0, dw = 0, cw = 0;
  logic         l2o, l3o, dwo, cwo;
  logic [27:0]  l2i = '0, l3i = '0, l2q, l3q;
  logic [71:0]  di = '0, dq;
  logic [23:0]  ci = '0, cq;
  logic [2:0]   ev = '0;
  logic [31:0]  mm [6];
  int           cnt [3];
  logic [2:0]   st;
  int           seed = 31004;
  int           checks = 0, n_mismatch = 0;
  localparam logic [10:0] MOFF [6] = '{OFF_LANE2, OFF_LANE3, OFF_RDATA_LO,
    OFF_RDATA_MID, OFF_RDATA_HI, OFF_RCTRL};
  localparam logic [31:0] MW [6] = '{32'h0fffffff, 32'h0fffffff,
    32'hffffffff, 32'hffffffff, 32'h000000ff, 32'h00ffffff};
  localparam logic [10:0] COFF [3] = '{OFF_TX_SBE, OFF_TX_MBE, OFF_RX_SBE};

  always #50 clk_in = ~clk_in;

  eiac_ecc_inject_count dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .lane2_wr_in(l2w), .lane2_word_in(l2i),
    .lane2_wr_out(l2o), .lane2_word_out(l2q), .lane3_wr_in(l3w),
    .lane3_word_in(l3i), .lane3_wr_out(l3o), .lane3_word_out(l3q),
    .rdata_wr_in(dw), .rdata_word_in(di), .rdata_wr_out(dwo),
    .rdata_word_out(dq), .rctrl_wr_in(cw), .rctrl_word_in(ci),
    .rctrl_wr_out(cwo), .rctrl_word_out(cq),
    .tx_single_bit_error_in(ev[0]), .tx_multi_bit_error_in(ev[1]),
    .rx_single_bit_error_in(ev[2]), .irq_out(irq));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [71:0] got, input logic [71:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [10:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    be    <= b;
    wr    <= w;
    rd    <= ~w;
    do begin
      @(posedge clk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    if (waitreq !== 1'b0) chk(1'b1, 1'b0, "bus answer");
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [10:0] a, input logic [31:0] e,
                        input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e, what);
  endtask

  task automatic pulse(input int i, input int n);
    repeat (n) begin
      @(posedge clk_in);
      ev[i] <= 1'b1;
    end
    @(posedge clk_in);
    ev <= 3'h0;
    cnt[i] = (cnt[i] + n > 255) ? 255 : cnt[i] + n;
    st[i] = 1'b1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #2_000_000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d, q;
    logic [3:0]  b;
    logic [27:0] p2, p3;
    logic [71:0] pd;
    logic [23:0] pc;
    int          nl [3];
    foreach (mm[i]) mm[i] = '0;
    foreach (cnt[i]) cnt[i] = 0;
    st = '0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(MOFF[i], 32'h0, "mask reset");
    for (int i = 0; i < 3; i++) rd_chk(COFF[i], 32'h0, "count reset");
    rd_chk(11'h3fc, 32'h0, "unmapped read");
    $display("test reset values done");
    bus(1'b1, 11'h3f0, 32'hffffffff, 4'hf, q);
    rd_chk(11'h3f0, 32'h0, "unmapped write");
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 6; i++) begin
        d = $random(seed);
        b = (r == 0) ? 4'hf : 4'($random(seed));
        bus(1'b1, MOFF[i], d, b, q);
        for (int k = 0; k < 4; k++) if (b[k]) mm[i][8*k+:8] = d[8*k+:8];
        mm[i] &= MW[i];
        rd_chk(MOFF[i], mm[i], "mask readback");
      end
    end
    $display("test mask registers done");
    p2 = '0; p3 = '0; pd = '0; pc = '0;
    for (int k = 0; k <= 9; k++) begin
      @(posedge clk_in);
      l2w <= (k < 8);
      l3w <= (k < 8);
      dw  <= (k < 8);
      cw  <= (k < 8);
      if (k < 8) begin
        l2i <= 28'($random(seed));
        l3i <= 28'($random(seed));
        di  <= {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
        ci  <= 24'($random(seed));
      end
      @(negedge clk_in);
      if (k > 0) begin
        chk({l2o, l3o, dwo, cwo}, {4{k <= 8}}, "strobe out");
        chk(l2q, p2 ^ mm[0][27:0], "lane2 word");
        chk(l3q, p3 ^ mm[1][27:0], "lane3 word");
        chk(dq, pd ^ {mm[4][7:0], mm[3], mm[2]}, "rate data");
        chk(cq, pc ^ mm[5][23:0], "rate ctrl");
      end
      if (k < 8) begin
        p2 = l2i; p3 = l3i; pd = di; pc = ci;
      end
    end
    $display("test injection done");
    for (int i = 0; i < 3; i++) begin
      nl = '{1 + ($random(seed) & 15), 255, 300};
      for (int j = 0; j < 3; j++) begin
        pulse(i, nl[j]);
        rd_chk(COFF[i], cnt[i], "count value");
        cnt[i] = 0;
        rd_chk(COFF[i], 32'h0, "count cleared");
      end
    end
    $display("test counters done");
    rd_chk(OFF_IRQ_STAT, {29'h0, st}, "status sticky");
    st = '0;
    bus(1'b1, OFF_IRQ_MASK, 32'h5, 4'hf, q);
    rd_chk(OFF_IRQ_MASK, 32'h5, "irq mask");
    for (int i = 0; i < 3; i++) begin
      pulse(i, 1);
      repeat (3) @(negedge clk_in);
      chk(irq, (i != 1), "irq raised");
      rd_chk(OFF_IRQ_STAT, 32'h1 << i, "status bit");
      st = '0;
      repeat (3) @(negedge clk_in);
      chk(irq, 1'b0, "irq cleared");
    end
    $display("test interrupts done");
    tally_and_finish();
  end
endmodule // eiac_ecc_inject_count_tb

`default_nettype wire
